// ==== src/pcm_filter.sv ====
// first-order low-pass filter for the summed peak current
`include "pcm_regs.svh"
module pcm_filter (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// sample in, filtered out
	input  wire pcm_pkg::pcm_cur_t sample_i,
	output pcm_pkg::pcm_cur_t      filt_o
);
	localparam int SH = `PCM_ADD_FILT_SHIFT;	// time constant near 1 us
	localparam int AW = `PCM_CW + SH;		// accumulator width

	logic [AW-1:0] acc;		// scaled running average
	logic [AW-1:0] next_acc;	// next accumulator

	// leak one part in 2^SH and add the new sample
	always_comb begin
		next_acc = acc - (acc >> SH) + AW'(sample_i);
	end

	// register the accumulator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	assign filt_o = acc[AW-1 -: `PCM_CW];	// scale back to current units
endmodule : pcm_filter

// ==== src/pcm_pkg.sv ====
// types shared by the phase count manager files
`include "pcm_regs.svh"
package pcm_pkg;
	typedef logic [`PCM_CW-1:0] pcm_cur_t;	// current or threshold word
	typedef logic [`PCM_NW-1:0] pcm_cnt_t;	// phase count or slot

	// shed decision state per channel
	typedef enum logic [0:0] {
		PCM_RUN       = 1'b0,	// steady, no shed pending
		PCM_SHED_WAIT = 1'b1	// shed condition seen, delay running
	} pcm_shed_e;
endpackage : pcm_pkg

// ==== src/pcm_regs.svh ====
// register offsets, field positions, reset values and timing constants of the phase count manager
// Functional notes
// - each channel picks its own phase count
// - shed enable zero keeps all enabled phases
// - never shed below programmed minimum count
// - shed from averaged current after delay
// - add from summed peak after 1us filter
// - add raw current, shed calibrated current
// - add threshold/hysteresis per count, one drop hysteresis
// - add when filtered peak exceeds threshold+hysteresis
// - shed below threshold minus i times hysteresis
// - each new pulse goes to next slot
// - ramp crossing control voltage requests a pulse
// - zero droop slope leaves setpoint unchanged
// - add and drop follow firing-order slots
// - slot zero never shed, drives frequency tick
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH

// sizes
`define PCM_NCH            2
`define PCM_NPIN           7
`define PCM_CW             16
`define PCM_NW             3
`define PCM_NTHR           8

// word offsets on the bus
`define PCM_ADR_CTRL0      8'h00
`define PCM_ADR_CAL0       8'h08
`define PCM_ADR_DROOP0     8'h10
`define PCM_ADR_STAT0      8'h18
`define PCM_ADR_PCFG0      8'h20
`define PCM_ADR_THR0       8'h40
`define PCM_ADR_END        8'h80
`define PCM_ADR_LSB        2
`define PCM_THR_CH_BIT     5

// control word fields
`define PCM_CTRL_SHED_EN   0
`define PCM_CTRL_MIN_LSB   4
`define PCM_CTRL_DHYST_LSB 16
`define PCM_CTRL_RST       32'h0000_0010

// calibration word fields
`define PCM_CAL_GAIN_LSB   0
`define PCM_CAL_OFS_LSB    16
`define PCM_CAL_FRAC       8
`define PCM_CAL_RST        32'h0000_0100

// droop word
`define PCM_DROOP_FRAC     8
`define PCM_DROOP_RST      32'h0000_0000

// phase configuration word fields
`define PCM_PCFG_EN        0
`define PCM_PCFG_PAGE      1
`define PCM_PCFG_ORD_LSB   4
`define PCM_PCFG_RST       32'h0000_0000

// threshold word fields
`define PCM_THR_ADD_LSB    0
`define PCM_THR_HYST_LSB   16
`define PCM_THR_RST        32'h0000_0000

// status word fields
`define PCM_STAT_CNT_LSB   0
`define PCM_STAT_NEN_LSB   4
`define PCM_STAT_WAIT      8

// timing
`define PCM_CLK_NS         10
`define PCM_ADD_FILT_NS    1000
`define PCM_ADD_FILT_CYC   ((`PCM_ADD_FILT_NS) / (`PCM_CLK_NS))
`define PCM_ADD_FILT_SHIFT ($clog2(`PCM_ADD_FILT_CYC))
`define PCM_SHED_DLY_NS    120000
`define PCM_SHED_DLY_CYC   (((`PCM_SHED_DLY_NS) + (`PCM_CLK_NS) - 1) / (`PCM_CLK_NS))

`endif

// ==== src/pcm_top.sv ====
// phase count manager: phase add/shed, pulse routing, droop, register slave
`include "pcm_regs.svh"
module pcm_top #(
	parameter int SHED_DLY_CYC = `PCM_SHED_DLY_CYC	// shed delay in clocks
) (
	// clock and reset
	input  wire logic                               clk_i,
	input  wire logic                               rst_i,
	// wishbone slave
	input  wire logic                               wb_cyc_i,
	input  wire logic                               wb_stb_i,
	input  wire logic                               wb_we_i,
	input  wire logic [7:0]                         wb_adr_i,
	input  wire logic [3:0]                         wb_sel_i,
	input  wire logic [31:0]                        wb_dat_i,
	output logic [31:0]                             wb_dat_o,
	output logic                                    wb_ack_o,
	// per-channel analog-domain samples
	input  wire logic [`PCM_NCH-1:0][`PCM_CW-1:0]   sum_peak_i,
	input  wire logic [`PCM_NCH-1:0][`PCM_CW-1:0]   iout_avg_i,
	input  wire logic [`PCM_NCH-1:0][`PCM_CW-1:0]   ramp_i,
	input  wire logic [`PCM_NCH-1:0][`PCM_CW-1:0]   comp_i,
	input  wire logic [`PCM_NCH-1:0][`PCM_CW-1:0]   vdac_i,
	// power stage side
	output logic [`PCM_NPIN-1:0]                    pwm_req_o,
	output logic [`PCM_NPIN-1:0]                    phase_on_o,
	output logic [`PCM_NCH-1:0]                     freq_tick_o,
	output logic [`PCM_NCH-1:0][`PCM_NW-1:0]        active_cnt_o,
	output logic [`PCM_NCH-1:0][`PCM_CW-1:0]        vset_o
);
	localparam int CW = `PCM_CW;
	localparam int NW = `PCM_NW;

	// register file
	logic [31:0] ctrl_q  [`PCM_NCH];	// shed enable, minimum, drop hysteresis
	logic [31:0] cal_q   [`PCM_NCH];	// current calibration gain and offset
	logic [31:0] droop_q [`PCM_NCH];	// droop slope
	logic [31:0] pcfg_q  [`PCM_NPIN];	// per-pin enable, page, order
	logic [31:0] thr_q   [`PCM_NCH][`PCM_NTHR];	// add threshold and hysteresis per count
	logic [31:0] next_ctrl  [`PCM_NCH];
	logic [31:0] next_cal   [`PCM_NCH];
	logic [31:0] next_droop [`PCM_NCH];
	logic [31:0] next_pcfg  [`PCM_NPIN];
	logic [31:0] next_thr   [`PCM_NCH][`PCM_NTHR];
	logic        next_ack;	// answer next cycle
	logic [31:0] next_rdat;	// read data for that answer
	logic [31:0] stat_w [`PCM_NCH];	// live status words

	// per-channel results
	logic [`PCM_NPIN-1:0] fire_w [`PCM_NCH];	// pin pulse this cycle
	logic [`PCM_NPIN-1:0] on_w   [`PCM_NCH];	// pins in the active set
	logic                 tick_w [`PCM_NCH];	// slot zero fired
	logic [CW-1:0]        vset_w [`PCM_NCH];	// droop-adjusted setpoint

	// byte-lane merge of a write
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// bus decode: ack one cycle after request, write lands on the ack edge
	always_comb begin
		logic       wr;
		logic [7:0] a;
		logic [7:0] toff;
		wr         = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
		a          = wb_adr_i;
		toff       = a - `PCM_ADR_THR0;
		next_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_rdat  = '0;	// unmapped reads as zero
		next_ctrl  = ctrl_q;
		next_cal   = cal_q;
		next_droop = droop_q;
		next_pcfg  = pcfg_q;
		next_thr   = thr_q;
		for (int c = 0; c < `PCM_NCH; c++) begin
			if (a == `PCM_ADR_CTRL0 + 8'(c << `PCM_ADR_LSB)) begin
				next_rdat = ctrl_q[c];
				if (wr) next_ctrl[c] = lane_merge(ctrl_q[c], wb_dat_i, wb_sel_i);
			end
			if (a == `PCM_ADR_CAL0 + 8'(c << `PCM_ADR_LSB)) begin
				next_rdat = cal_q[c];
				if (wr) next_cal[c] = lane_merge(cal_q[c], wb_dat_i, wb_sel_i);
			end
			if (a == `PCM_ADR_DROOP0 + 8'(c << `PCM_ADR_LSB)) begin
				next_rdat = droop_q[c];
				if (wr) next_droop[c] = lane_merge(droop_q[c], wb_dat_i, wb_sel_i);
			end
			if (a == `PCM_ADR_STAT0 + 8'(c << `PCM_ADR_LSB)) begin
				next_rdat = stat_w[c];	// read only
			end
		end
		for (int p = 0; p < `PCM_NPIN; p++) begin
			if (a == `PCM_ADR_PCFG0 + 8'(p << `PCM_ADR_LSB)) begin
				next_rdat = pcfg_q[p];
				if (wr) next_pcfg[p] = lane_merge(pcfg_q[p], wb_dat_i, wb_sel_i);
			end
		end
		// threshold table, one word per channel and count
		if (a >= `PCM_ADR_THR0 && a < `PCM_ADR_END) begin
			next_rdat = thr_q[toff[`PCM_THR_CH_BIT]][toff[`PCM_ADR_LSB +: NW]];
			if (wr) begin
				next_thr[toff[`PCM_THR_CH_BIT]][toff[`PCM_ADR_LSB +: NW]] = lane_merge(
					thr_q[toff[`PCM_THR_CH_BIT]][toff[`PCM_ADR_LSB +: NW]],
					wb_dat_i, wb_sel_i);
			end
		end
	end

	// register file and bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			for (int c = 0; c < `PCM_NCH; c++) begin
				ctrl_q[c]  <= `PCM_CTRL_RST;
				cal_q[c]   <= `PCM_CAL_RST;
				droop_q[c] <= `PCM_DROOP_RST;
				for (int n = 0; n < `PCM_NTHR; n++) begin
					thr_q[c][n] <= `PCM_THR_RST;
				end
			end
			for (int p = 0; p < `PCM_NPIN; p++) begin
				pcfg_q[p] <= `PCM_PCFG_RST;
			end
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_ack ? next_rdat : '0;
			ctrl_q   <= next_ctrl;
			cal_q    <= next_cal;
			droop_q  <= next_droop;
			pcfg_q   <= next_pcfg;
			thr_q    <= next_thr;
		end
	end

	// one independent phase manager per channel
	for (genvar g = 0; g < `PCM_NCH; g++) begin : g_ch
		pcm_pkg::pcm_cur_t   filt;		// filtered summed peak
		pcm_pkg::pcm_cnt_t   cnt, next_cnt;	// active phase count
		pcm_pkg::pcm_cnt_t   slot, next_slot;	// next firing slot
		pcm_pkg::pcm_shed_e  st, next_st;	// shed state
		logic [31:0]         dly, next_dly;	// shed delay counter
		logic                above, next_above;	// ramp above control
		pcm_pkg::pcm_cnt_t   n_en;		// pins enabled on channel
		logic [`PCM_NPIN-1:0] mine;		// pins on this channel
		logic [CW-1:0]       vset, next_vset;	// registered setpoint

		pcm_filter u_filt (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.sample_i (sum_peak_i[g]),
			.filt_o   (filt)
		);

		// next count, slot and routing
		always_comb begin
			logic                shed_en;
			pcm_pkg::pcm_cnt_t   floor_c;
			logic [CW-1:0]       dh;
			logic [31:0]         thr_up, thr_cur;
			logic [CW:0]         add_lim;
			logic                add_go, shed_go, req;
			logic signed [25:0]  avg_cal, shed_lim;
			logic [CW+NW-1:0]    hmul;
			logic [31:0]         prod;
			logic [CW+CW-1:0]    dmul;
			logic [CW-1:0]       avg_pos, drop;
			pcm_pkg::pcm_cnt_t   s1;
			shed_en  = ctrl_q[g][`PCM_CTRL_SHED_EN];
			dh       = ctrl_q[g][`PCM_CTRL_DHYST_LSB +: CW];
			mine     = '0;
			n_en     = '0;
			for (int p = 0; p < `PCM_NPIN; p++) begin
				mine[p] = pcfg_q[p][`PCM_PCFG_EN] && (pcfg_q[p][`PCM_PCFG_PAGE] == 1'(g));
				n_en    = n_en + NW'(mine[p]);
			end
			// slot zero is never shed, and the floor never exceeds what is enabled
			floor_c = ctrl_q[g][`PCM_CTRL_MIN_LSB +: NW];
			if (floor_c == '0) floor_c = NW'(1);
			if (floor_c > n_en) floor_c = n_en;
			// add: raw filtered peak against threshold plus hysteresis of count+1
			thr_up  = thr_q[g][NW'(cnt + NW'(1))];
			add_lim = {1'b0, thr_up[`PCM_THR_ADD_LSB +: CW]}
				+ {1'b0, thr_up[`PCM_THR_HYST_LSB +: CW]};
			add_go  = (cnt < n_en) && ({1'b0, filt} > add_lim);
			// shed: calibrated average against threshold of count minus (count-1) hysteresis
			prod     = 32'(iout_avg_i[g]) * 32'(cal_q[g][`PCM_CAL_GAIN_LSB +: CW]);
			avg_cal  = $signed({2'b00, prod[`PCM_CAL_FRAC +: 24]})
				+ 26'($signed(cal_q[g][`PCM_CAL_OFS_LSB +: CW]));
			thr_cur  = thr_q[g][cnt];
			hmul     = (CW+NW)'(NW'(cnt - NW'(1))) * (CW+NW)'(dh);
			shed_lim = $signed({10'h000, thr_cur[`PCM_THR_ADD_LSB +: CW]})
				- $signed({7'h00, hmul});
			shed_go  = (cnt > floor_c) && (avg_cal < shed_lim);
			// count decision: add and shed one phase at a time, shed off or a count above n_en jumps straight to n_en
			next_cnt = cnt;
			next_st  = pcm_pkg::PCM_RUN;
			next_dly = '0;
			if (!shed_en) begin
				next_cnt = n_en;
			end else if (cnt > n_en) begin
				next_cnt = n_en;
			end else if (cnt < floor_c) begin
				next_cnt = cnt + NW'(1);
			end else if (add_go) begin
				next_cnt = cnt + NW'(1);
			end else if (shed_go) begin
				if (dly >= 32'(SHED_DLY_CYC - 1)) begin
					next_cnt = cnt - NW'(1);
				end else begin
					next_st  = pcm_pkg::PCM_SHED_WAIT;
					next_dly = dly + 32'h1;
				end
			end
			// otherwise the delay restarts from zero
			// pulse request on ramp crossing the control voltage
			next_above = ramp_i[g] >= comp_i[g];
			req        = next_above && !above;
			fire_w[g]  = '0;
			on_w[g]    = '0;
			tick_w[g]  = 1'b0;
			for (int p = 0; p < `PCM_NPIN; p++) begin
				on_w[g][p] = mine[p] && (pcfg_q[p][`PCM_PCFG_ORD_LSB +: NW] < cnt);
				if (req && cnt != '0 && mine[p]
						&& pcfg_q[p][`PCM_PCFG_ORD_LSB +: NW] == slot) begin
					fire_w[g][p] = 1'b1;
				end
			end
			s1 = slot + NW'(1);
			if (req && cnt != '0) begin
				tick_w[g] = (slot == '0);
				next_slot = (s1 >= cnt) ? '0 : s1;
			end else begin
				next_slot = slot;
			end
			if (next_slot >= next_cnt) next_slot = '0;
			// droop: setpoint lowered by slope times calibrated current
			avg_pos   = (avg_cal < 0) ? '0 :
				((avg_cal > 26'sh000ffff) ? '1 : avg_cal[CW-1:0]);
			dmul      = (2*CW)'(avg_pos) * (2*CW)'(droop_q[g][CW-1:0]);
			drop      = (dmul[2*CW-1 -: (CW-`PCM_DROOP_FRAC)] != '0) ? '1 :
				dmul[`PCM_DROOP_FRAC +: CW];
			next_vset = (drop > vdac_i[g]) ? '0 : vdac_i[g] - drop;
			vset_w[g] = vset;
			stat_w[g] = '0;
			stat_w[g][`PCM_STAT_CNT_LSB +: NW] = cnt;
			stat_w[g][`PCM_STAT_NEN_LSB +: NW] = n_en;
			stat_w[g][`PCM_STAT_WAIT]           = (st == pcm_pkg::PCM_SHED_WAIT);
		end

		// channel state registers
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt   <= '0;
				slot  <= '0;
				st    <= pcm_pkg::PCM_RUN;
				dly   <= '0;
				above <= 1'b0;
				vset  <= '0;
			end else begin
				cnt   <= next_cnt;
				slot  <= next_slot;
				st    <= next_st;
				dly   <= next_dly;
				above <= next_above;
				vset  <= next_vset;
			end
		end

		assign active_cnt_o[g] = cnt;
		assign vset_o[g]       = vset_w[g];
	end

	// pin outputs
	logic [`PCM_NPIN-1:0] next_pwm, next_on;
	logic [`PCM_NCH-1:0]  next_tick;

	// merge both channels onto the shared pins
	always_comb begin
		next_pwm  = fire_w[0] | fire_w[1];
		next_on   = on_w[0] | on_w[1];
		next_tick = {tick_w[1], tick_w[0]};
	end

	// register the pin outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_req_o   <= '0;
			phase_on_o  <= '0;
			freq_tick_o <= '0;
		end else begin
			pwm_req_o   <= next_pwm;
			phase_on_o  <= next_on;
			freq_tick_o <= next_tick;
		end
	end
endmodule : pcm_top

// ==== verification/pcm_stage_model.sv ====
// power stage model: flags pulses that reach a stage outside the active set
module pcm_stage_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// per pin pulse and active level
	input  wire logic [6:0] pwm_req_i,
	input  wire logic [6:0] phase_on_i,
	// stray pulse count
	output int              bad_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// a stage held off must never be pulsed
	always @(posedge clk_i) begin
		if (rst_i) begin
			bad_o <= 0;
		end else if ((pwm_req_i & ~phase_on_i) != 7'h00) begin
			bad_o <= bad_o + 1;
		end
	end
endmodule : pcm_stage_model

// ==== verification/pcm_top_asserts.sv ====
// port checks of the phase count manager, bound to its top
`include "pcm_regs.svh"
module pcm_top_asserts #(
	parameter int SHED_DLY_CYC = `PCM_SHED_DLY_CYC	// shed delay in clocks
) (
	// clock and reset
	input wire logic                             clk_i,
	input wire logic                             rst_i,
	// bus
	input wire logic                             wb_cyc_i,
	input wire logic                             wb_stb_i,
	input wire logic [31:0]                      wb_dat_o,
	input wire logic                             wb_ack_o,
	// pulse path and counts
	input wire logic [`PCM_NCH-1:0][`PCM_CW-1:0] ramp_i,
	input wire logic [`PCM_NCH-1:0][`PCM_CW-1:0] comp_i,
	input wire logic [`PCM_NPIN-1:0]             pwm_req_o,
	input wire logic [`PCM_NPIN-1:0]             phase_on_o,
	input wire logic [`PCM_NCH-1:0]              freq_tick_o,
	input wire logic [`PCM_NCH-1:0][`PCM_NW-1:0] active_cnt_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] ramp_up;	// ramp at or above control, per channel
	logic [2:0] prev_cnt;	// ch0 count one edge back
	int         stable;	// edges since ch0 count last moved
	int         next_stable;	// next age
	assign ramp_up = {ramp_i[1] >= comp_i[1], ramp_i[0] >= comp_i[0]};
	// age restarts whenever the count moves
	always_comb next_stable = (active_cnt_o[0] != prev_cnt) ? 0 : stable + 1;
	// age and previous count registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stable <= 0;
			prev_cnt <= 3'h0;
		end else begin
			stable <= next_stable;
			prev_cnt <= active_cnt_o[0];
		end
	end
	sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
	sequence s_cross0; ramp_up[0] && !$past(ramp_up[0]) && active_cnt_o[0] != 3'h0; endsequence
	property p_ack; $rose(wb_cyc_i && wb_stb_i) |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat: assert property (p_dat) else $error("read data without ack");
	property p_req; s_cross0 |=> pwm_req_o != 7'h00; endproperty
	a_req: assert property (p_req) else $error("crossing gave no pulse");
	property p_cause; pwm_req_o != 7'h00 |-> ($past(ramp_up) & ~$past(ramp_up, 2)) != 2'h0; endproperty
	a_cause: assert property (p_cause) else $error("pulse without crossing");
	property p_tick; freq_tick_o != 2'h0 |-> pwm_req_o != 7'h00; endproperty
	a_tick: assert property (p_tick) else $error("tick without pulse");
	property p_step; active_cnt_o[0] > prev_cnt |-> active_cnt_o[0] == prev_cnt + 3'h1; endproperty
	a_step: assert property (p_step) else $error("count rose by more than one");
	property p_shed; active_cnt_o[0] < prev_cnt |-> stable >= SHED_DLY_CYC - 2; endproperty
	a_shed: assert property (p_shed) else $error("shed before delay ran out");
	property p_on;
		$countones(phase_on_o) == $past(active_cnt_o[0]) + $past(active_cnt_o[1]);
	endproperty
	a_on: assert property (p_on) else $error("active pins differ from counts");
endmodule : pcm_top_asserts
bind pcm_top pcm_top_asserts #(.SHED_DLY_CYC(SHED_DLY_CYC)) pcm_top_asserts_inst (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .ramp_i, .comp_i, .pwm_req_o, .phase_on_o,
	.freq_tick_o, .active_cnt_o);

// ==== verification/tb_top.sv ====
// self-checking bench of the phase count manager
`include "pcm_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DLY = 20;	// short shed delay
	logic             clk_i, rst_i, cyc, stb, we, ack;	// clock, reset, bus
	logic [7:0]       adr;	// bus address
	logic [3:0]       sel;	// byte lanes
	logic [31:0]      dat, dat_o, rd;	// bus data
	logic [1:0][15:0] peak, iavg, ramp, comp, vdac, vset;	// channel words
	logic [6:0]       pwm, pon;	// pin outputs
	logic [1:0]       tick;	// frequency ticks
	logic [1:0][2:0]  cnt;	// active counts
	int               miscompares, tests_run, bad, n;	// tallies
	pcm_top #(.SHED_DLY_CYC(DLY)) pcm_top_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .sum_peak_i(peak), .iout_avg_i(iavg), .ramp_i(ramp), .comp_i(comp),
		.vdac_i(vdac), .pwm_req_o(pwm), .phase_on_o(pon), .freq_tick_o(tick),
		.active_cnt_o(cnt), .vset_o(vset));
	pcm_stage_model pcm_stage_model_inst (.clk_i, .rst_i, .pwm_req_i(pwm), .phase_on_i(pon),
		.bad_o(bad));
	// free running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// counts and reports one comparison
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	// counts, verdict, end of run
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	// one classic bus cycle held until ack; read data lands in rd
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k == 20) begin
			miscompares++;
			print_verdict();
		end
	endtask : wb
	// bounded wait for the ch0 count
	task wcnt(input logic [2:0] v, input int lim);
		for (n = 0; n < lim && cnt[0] !== v; n++) @(posedge clk_i);
		if (n == lim) begin
			miscompares++;
			print_verdict();
		end
	endtask : wcnt
	// one ramp crossing on channel c, pulse and tick checked after the edge
	task pls(input int c, input logic [6:0] e, input logic [1:0] t);
		@(posedge clk_i);
		ramp[c] <= 16'h0020;
		@(posedge clk_i);
		ramp[c] <= 16'h0000;
		#1;
		chk("pulse and tick", 32'({e, t}), 32'({pwm, tick}));
	endtask : pls
	// ctrl0 reset value, unmapped word, threshold round trip
	task t_regs;
		wb(1'b0, `PCM_ADR_CTRL0, 32'h0);
		chk("ctrl0", `PCM_CTRL_RST, rd);
		wb(1'b0, `PCM_ADR_END, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, `PCM_ADR_THR0 + 8'h08, 32'h0014_0064);	// count 2: add 100, hysteresis 20
		wb(1'b0, `PCM_ADR_THR0 + 8'h08, 32'h0);
		chk("thr2", 32'h0014_0064, rd);
		$display("test regs done");
	endtask : t_regs
	// shed on, floor one, gain two, ch0 pins 0 and 2, ch1 pin 6
	task t_cfg;
		wb(1'b1, `PCM_ADR_CTRL0, 32'h000a_0011);	// drop hysteresis 10
		wb(1'b1, `PCM_ADR_CAL0, 32'h0000_0200);
		wb(1'b1, `PCM_ADR_PCFG0, 32'h0000_0001);
		wb(1'b1, `PCM_ADR_PCFG0 + 8'h08, 32'h0000_0011);
		wb(1'b1, `PCM_ADR_PCFG0 + 8'h18, 32'h0000_0003);
		repeat (3 * DLY) @(posedge clk_i);
		chk("floor", 32'h1, 32'(cnt[0]));
		chk("ch1", 32'h1, 32'(cnt[1]));
		chk("setpoint", 32'h1234, 32'(vset[0]));
		$display("test cfg done");
	endtask : t_cfg
	// add path on raw filtered peak
	task t_add;
		peak[0] <= 16'd100;
		repeat (600) @(posedge clk_i);
		chk("no add", 32'h1, 32'(cnt[0]));
		peak[0] <= 16'd200;
		repeat (10) @(posedge clk_i);
		chk("filtered", 32'h1, 32'(cnt[0]));
		wcnt(3'h2, 600);
		repeat (50) @(posedge clk_i);
		chk("capped", 32'h2, 32'(cnt[0]));
		$display("test add done");
	endtask : t_add
	// pulses rotate over active slots in firing order
	task t_pulse;
		chk("active pins", 32'h45, 32'(pon));
		pls(0, 7'h01, 2'h1);
		pls(0, 7'h04, 2'h0);
		pls(0, 7'h01, 2'h1);
		pls(1, 7'h40, 2'h2);
		pls(0, 7'h04, 2'h0);
		chk("stage", 32'h0, 32'(bad));
		$display("test pulse done");
	endtask : t_pulse
	// shed on calibrated average, restart, delay, floor
	task t_shed;
		wb(1'b1, `PCM_ADR_THR0 + 8'h0c, 32'h0000_7000);
		peak[0] <= 16'h0000;
		repeat (3 * DLY) @(posedge clk_i);
		chk("calibrated hold", 32'h2, 32'(cnt[0]));
		iavg[0] <= 16'd40;
		repeat (DLY - 5) @(posedge clk_i);
		iavg[0] <= 16'd50;
		@(posedge clk_i);
		iavg[0] <= 16'd40;
		repeat (DLY - 5) @(posedge clk_i);
		chk("restarted", 32'h2, 32'(cnt[0]));
		wcnt(3'h1, 20);
		chk("shed time", 32'h1, 32'(n >= 3 && n <= 9));
		repeat (3 * DLY) @(posedge clk_i);
		chk("floor kept", 32'h1, 32'(cnt[0]));
		$display("test shed done");
	endtask : t_shed
	// shed off keeps every enabled pin; status is read only
	task t_noshed;
		wb(1'b1, `PCM_ADR_CTRL0, 32'h000a_0010);
		repeat (3 * DLY) @(posedge clk_i);
		chk("all on", 32'h2, 32'(cnt[0]));
		wb(1'b1, `PCM_ADR_STAT0, 32'hffff_ffff);
		wb(1'b0, `PCM_ADR_STAT0, 32'h0);
		chk("status", 32'h0000_0022, rd);
		wb(1'b1, `PCM_ADR_DROOP0, 32'h0000_0100);	// slope 1.0, current 40 times gain 2
		repeat (3) @(posedge clk_i);
		chk("droop", 32'h0000_11e4, 32'(vset[0]));
		$display("test no shed done");
	endtask : t_noshed
	// reset, then the scenarios in order
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, dat} = '0;
		sel = 4'hf;
		{peak, ramp} = '0;
		iavg = {16'd50, 16'd50};
		comp = {16'h0010, 16'h0010};
		vdac = {16'h1234, 16'h1234};
		miscompares = 0;
		tests_run = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_cfg();
		t_add();
		t_pulse();
		t_shed();
		t_noshed();
		print_verdict();
	end
endmodule : tb_top
